/* File: hw/gauge_pkg.sv */
// constants, mode codes and widths for the gauge power-mode supervisor
// assumes measurements arrive as two's complement words on the system clock
package gauge_pkg;

  localparam int unsigned DW = 16;
  localparam int unsigned TAPER_WINDOWS = 2;
  // minimum capacity gain per taper window, in uAh
  localparam logic [DW-1:0] MIN_GAIN_UAH = 16'h00FA;
  localparam logic [DW-1:0] WAKE_BASE_UV = 16'h04E2;
  localparam logic [1:0] PFC_INHIBIT = 2'h1;

  localparam int unsigned EV_ADDR = 0;
  localparam int unsigned EV_RESET = 1;
  localparam int unsigned EV_HIB = 2;
  localparam int unsigned EV_TQUERY = 3;
  localparam int unsigned EV_N = 4;

  typedef enum logic [8:0] {
    ST_INSERT_WAIT = 9'h001,
    ST_INSERT_SERVE = 9'h002,
    ST_INIT_OCV = 9'h004,
    ST_INIT_PROFILE = 9'h008,
    ST_NORMAL = 9'h010,
    ST_IDLE_CAL = 9'h020,
    ST_IDLE = 9'h040,
    ST_FAST_IDLE = 9'h080,
    ST_HIBERNATE = 9'h100
  } power_mode_t;

endpackage : gauge_pkg

/* File: hw/gauge_power_mode_supervisor.sv */
// power-mode sequencer, temperature flags, charge termination and wake comparator
// assumes measurement and flash logic on clk; host link logic on link_clk
`timescale 1ns/1ps
module gauge_power_mode_supervisor import gauge_pkg::*; #(
  parameter int unsigned RC_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_frame_done,
  input wire logic link_addr_match,
  input wire logic link_cmd_reset,
  input wire logic link_cmd_hibernate,
  input wire logic link_cmd_temp_query,
  input wire logic battery_present_pin,
  input wire logic measure_tick,
  input wire logic signed [DW-1:0] thermistor_input,
  input wire logic signed [DW-1:0] internal_temp,
  input wire logic temp_source_select,
  input wire logic [1:0] power_feed_config,
  input wire logic signed [DW-1:0] avg_current,
  input wire logic [DW-1:0] voltage,
  input wire logic signed [DW-1:0] sense_uv,
  input wire logic signed [DW-1:0] charge_hot_limit,
  input wire logic signed [DW-1:0] charge_recovery,
  input wire logic [DW-1:0] charge_hot_time,
  input wire logic signed [DW-1:0] charge_current_threshold,
  input wire logic signed [DW-1:0] discharge_hot_limit,
  input wire logic signed [DW-1:0] discharge_recovery,
  input wire logic [DW-1:0] discharge_hot_time,
  input wire logic signed [DW-1:0] discharge_current_threshold,
  input wire logic taper_window_end,
  input wire logic signed [DW-1:0] taper_current,
  input wire logic [DW-1:0] window_gain_uah,
  input wire logic [DW-1:0] charging_voltage,
  input wire logic [DW-1:0] taper_voltage,
  input wire logic remaining_equals_full_on_term,
  input wire logic [DW-1:0] full_charge_capacity,
  input wire logic capacity_update,
  input wire logic [DW-1:0] remaining_in,
  input wire logic signed [DW-1:0] inhibit_temp_low,
  input wire logic signed [DW-1:0] inhibit_temp_high,
  input wire logic signed [DW-1:0] temp_hys,
  input wire logic good_polarity_select,
  input wire logic idle_enable,
  input wire logic fast_idle_enable,
  input wire logic signed [DW-1:0] idle_current,
  input wire logic [DW-1:0] hibernate_current,
  input wire logic [DW-1:0] hibernate_voltage,
  input wire logic ocv_valid,
  input wire logic ocv_done,
  input wire logic profile_done,
  input wire logic cal_done,
  input wire logic cmd_done,
  input wire logic sense_range_hi,
  input wire logic sense_range_lo,
  input wire logic wake_threshold_range,
  input wire logic flash_write_req,
  input wire logic [DW-1:0] flash_ok_voltage,
  output logic battery_good_out,
  output logic charge_hot_flag,
  output logic discharge_hot_flag,
  output logic charging_flag,
  output logic charge_term,
  output logic [DW-1:0] remaining_capacity,
  output logic signed [DW-1:0] temperature,
  output power_mode_t power_mode,
  output logic cpu_halted,
  output logic hf_osc_enable,
  output logic ocv_start,
  output logic profile_start,
  output logic cal_start,
  output logic [RC_W-1:0] reset_count,
  output logic wake_irq,
  output logic flash_grant,
  output logic flash_refused
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [DW-1:0] magnitude(input logic signed [DW-1:0] v);
    magnitude = v[DW-1] ? DW'(-v) : DW'(v);
  endfunction : magnitude

  // zero means the comparator is off
  function automatic logic [DW-1:0] wake_level(input logic [1:0] code, input logic rng);
    logic [2:0] sh;
    sh = 3'(code) - 3'h1 + 3'(rng);
    wake_level = (code == 2'h0) ? '0 : (WAKE_BASE_UV << sh);
  endfunction : wake_level

  // ****************************************
  // resets
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] lrst_sync;
  logic lrst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) lrst_sync <= 2'h0;
    else lrst_sync <= {lrst_sync[0], 1'b1};
  end
  assign lrst_n = lrst_sync[1];

  // ****************************************
  // host link events
  // ****************************************
  // one toggle per event kind; only frames addressed to us count
  logic [EV_N-1:0] link_tgl;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      link_tgl <= '0;
    end else if (link_frame_done && link_addr_match) begin
      link_tgl <= link_tgl ^ {link_cmd_temp_query, link_cmd_hibernate, link_cmd_reset, 1'b1};
    end
  end

  logic [EV_N-1:0] tgl_s1;
  logic [EV_N-1:0] tgl_s2;
  logic [EV_N-1:0] tgl_s3;
  logic [EV_N-1:0] ev;
  logic pres_s1;
  logic present;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1 <= '0;
      tgl_s2 <= '0;
      tgl_s3 <= '0;
      pres_s1 <= 1'b0;
      present <= 1'b0;
    end else begin
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      pres_s1 <= battery_present_pin;
      present <= pres_s1;
    end
  end
  assign ev = tgl_s2 ^ tgl_s3;

  // ****************************************
  // temperature sampling
  // ****************************************
  logic signed [DW-1:0] temp_src;
  logic temp_take;
  assign temp_src = temp_source_select ? thermistor_input : internal_temp;
  // periodic sampling is skipped outside inhibit mode to save energy
  assign temp_take = (power_feed_config == PFC_INHIBIT) ? measure_tick : ev[EV_TQUERY];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) temperature <= '0;
    else if (temp_take) temperature <= temp_src;
  end

  // ****************************************
  // overtemperature
  // ****************************************
  logic [DW-1:0] chg_hot_cnt;
  logic [DW-1:0] dsg_hot_cnt;
  logic discharging;
  assign discharging = avg_current[DW-1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) chg_hot_cnt <= '0;
    else if (!charging_flag || temperature < charge_hot_limit) chg_hot_cnt <= '0;
    else if (measure_tick && chg_hot_cnt != charge_hot_time) chg_hot_cnt <= chg_hot_cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) charge_hot_flag <= 1'b0;
    else if (charge_hot_time == '0) charge_hot_flag <= 1'b0;
    else if (chg_hot_cnt == charge_hot_time && avg_current > charge_current_threshold)
      charge_hot_flag <= 1'b1;
    else if (temperature <= charge_recovery) charge_hot_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dsg_hot_cnt <= '0;
    else if (!discharging || temperature < discharge_hot_limit) dsg_hot_cnt <= '0;
    else if (measure_tick && dsg_hot_cnt != discharge_hot_time) dsg_hot_cnt <= dsg_hot_cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) discharge_hot_flag <= 1'b0;
    else if (discharge_hot_time == '0) discharge_hot_flag <= 1'b0;
    else if (dsg_hot_cnt == discharge_hot_time && avg_current <= -discharge_current_threshold)
      discharge_hot_flag <= 1'b1;
    else if (temperature <= discharge_recovery) discharge_hot_flag <= 1'b0;
  end

  // ****************************************
  // charge termination
  // ****************************************
  logic [1:0] taper_cnt;
  logic taper_ok;
  logic term_event;
  logic term_hold;
  assign taper_ok = avg_current < taper_current && window_gain_uah > MIN_GAIN_UAH
    && voltage > charging_voltage - taper_voltage;
  assign term_event = charging_flag && taper_window_end && taper_ok
    && taper_cnt == 2'(TAPER_WINDOWS - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) taper_cnt <= '0;
    else if (!charging_flag) taper_cnt <= '0;
    else if (taper_window_end && !taper_ok) taper_cnt <= '0;
    else if (taper_window_end && taper_cnt != 2'(TAPER_WINDOWS)) taper_cnt <= taper_cnt + 1'b1;
  end

  // after termination charging is not flagged again until current relaxes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charging_flag <= 1'b0;
      term_hold <= 1'b0;
    end else if (term_event) begin
      charging_flag <= 1'b0;
      term_hold <= 1'b1;
    end else if (discharging || avg_current == '0) begin
      term_hold <= 1'b0;
      charging_flag <= 1'b0;
    end else if (!term_hold && avg_current > charge_current_threshold) begin
      charging_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) charge_term <= 1'b0;
    else charge_term <= term_event;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) remaining_capacity <= '0;
    else if (term_event && remaining_equals_full_on_term)
      remaining_capacity <= full_charge_capacity;
    else if (capacity_update) remaining_capacity <= remaining_in;
  end

  // ****************************************
  // charge inhibit and battery-good
  // ****************************************
  logic inhibit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) inhibit <= 1'b0;
    else if (power_feed_config != PFC_INHIBIT) inhibit <= 1'b0;
    else if (temperature < inhibit_temp_low || temperature > inhibit_temp_high)
      inhibit <= 1'b1;
    else if (temperature >= inhibit_temp_low + temp_hys
             && temperature <= inhibit_temp_high - temp_hys)
      inhibit <= 1'b0;
  end

  logic good_enable;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) battery_good_out <= 1'b1;
    else if (good_enable && !inhibit) battery_good_out <= good_polarity_select;
    else battery_good_out <= ~good_polarity_select;
  end

  // ****************************************
  // wake comparator
  // ****************************************
  logic [DW-1:0] wake_thr;
  logic wake_hit;
  logic low_power;
  assign wake_thr = wake_level({sense_range_hi, sense_range_lo}, wake_threshold_range);
  assign low_power = power_mode == ST_IDLE || power_mode == ST_FAST_IDLE
    || power_mode == ST_HIBERNATE;
  // both current directions trip through the magnitude
  assign wake_hit = low_power && wake_thr != '0 && magnitude(sense_uv) > wake_thr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wake_irq <= 1'b0;
    else wake_irq <= wake_hit;
  end

  // ****************************************
  // host requests
  // ****************************************
  logic hib_req;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hib_req <= 1'b0;
    else if (ev[EV_HIB]) hib_req <= 1'b1;
    else if (power_mode == ST_HIBERNATE) hib_req <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reset_count <= '0;
    else if (ev[EV_RESET]) reset_count <= reset_count + 1'b1;
  end

  // ****************************************
  // power mode sequencer
  // ****************************************
  power_mode_t next_mode;
  logic idle_low;
  logic hib_ok;
  assign idle_low = avg_current < idle_current;
  assign hib_ok = hib_req && ocv_valid
    && (magnitude(avg_current) < hibernate_current || voltage < hibernate_voltage);

  always_comb begin
    next_mode = power_mode;
    unique case (power_mode)
      ST_INSERT_WAIT: begin
        if (present) next_mode = ST_INIT_OCV;
        else if (ev[EV_ADDR]) next_mode = ST_INSERT_SERVE;
      end
      ST_INSERT_SERVE: begin
        if (cmd_done) next_mode = ST_INSERT_WAIT;
      end
      ST_INIT_OCV: begin
        if (ocv_done) next_mode = ST_INIT_PROFILE;
      end
      ST_INIT_PROFILE: begin
        if (profile_done) next_mode = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (hib_ok) next_mode = ST_HIBERNATE;
        else if (fast_idle_enable && idle_low) next_mode = ST_FAST_IDLE;
        else if (idle_enable && idle_low) next_mode = ST_IDLE_CAL;
      end
      ST_IDLE_CAL: begin
        if (!idle_low || !idle_enable) next_mode = ST_NORMAL;
        else if (cal_done) next_mode = ST_IDLE;
      end
      ST_IDLE: begin
        if (avg_current > idle_current || wake_hit) next_mode = ST_NORMAL;
      end
      ST_FAST_IDLE: begin
        if (ev[EV_ADDR] || avg_current > idle_current || wake_hit)
          next_mode = ST_NORMAL;
      end
      ST_HIBERNATE: begin
        if (ev[EV_ADDR]) next_mode = ST_INIT_OCV;
      end
      default: next_mode = ST_INSERT_WAIT;
    endcase
    // removal overrides every other mode except the insertion serve step
    if (!present && next_mode != ST_INSERT_SERVE) next_mode = ST_INSERT_WAIT;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) power_mode <= ST_INSERT_WAIT;
    else power_mode <= next_mode;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ocv_start <= 1'b0;
      profile_start <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      ocv_start <= next_mode == ST_INIT_OCV && power_mode != ST_INIT_OCV;
      profile_start <= next_mode == ST_INIT_PROFILE && power_mode != ST_INIT_PROFILE;
      cal_start <= next_mode == ST_IDLE_CAL && power_mode != ST_IDLE_CAL;
    end
  end

  // battery-good stays disabled until the first voltage reading is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) good_enable <= 1'b0;
    else if (next_mode == ST_INSERT_WAIT || next_mode == ST_HIBERNATE
             || next_mode == ST_INIT_OCV) good_enable <= 1'b0;
    else if (power_mode == ST_INIT_OCV && ocv_done) good_enable <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halted <= 1'b1;
      hf_osc_enable <= 1'b1;
    end else begin
      cpu_halted <= next_mode == ST_INSERT_WAIT;
      hf_osc_enable <= next_mode != ST_IDLE && next_mode != ST_HIBERNATE;
    end
  end

  // ****************************************
  // flash update gate
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_grant <= 1'b0;
      flash_refused <= 1'b0;
    end else begin
      flash_grant <= flash_write_req && voltage >= flash_ok_voltage;
      flash_refused <= flash_write_req && voltage < flash_ok_voltage;
    end
  end

endmodule : gauge_power_mode_supervisor

/* File: sim/gauge_power_mode_supervisor_assertions.sv */
// assertion checker for the gauge power-mode supervisor
// assumes it sees only the top module's clk-domain ports, attached by bind
`timescale 1ns/1ps
module gauge_supervisor_checker import gauge_pkg::*; #(
  parameter int unsigned RC_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire power_mode_t power_mode,
  input wire logic ocv_start,
  input wire logic profile_start,
  input wire logic cpu_halted,
  input wire logic hf_osc_enable,
  input wire logic ocv_valid,
  input wire logic flash_write_req,
  input wire logic [DW-1:0] voltage,
  input wire logic [DW-1:0] flash_ok_voltage,
  input wire logic flash_grant,
  input wire logic flash_refused,
  input wire logic [DW-1:0] charge_hot_time,
  input wire logic charge_hot_flag,
  input wire logic charge_term,
  input wire logic charging_flag,
  input wire logic [RC_W-1:0] reset_count,
  input wire logic wake_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ****
  // power sequence
  // ****
  a_ocv_on_entry: assert property (ocv_start |->
    power_mode == ST_INIT_OCV && $past(power_mode) != ST_INIT_OCV)
    else $error("ocv start without entry to the ocv step");
  a_profile_after_ocv: assert property (profile_start |->
    power_mode == ST_INIT_PROFILE && $past(power_mode) == ST_INIT_OCV)
    else $error("profile start not right after the ocv step");
  a_cal_before_idle: assert property (power_mode == ST_IDLE && $past(power_mode) != ST_IDLE |->
    $past(power_mode) == ST_IDLE_CAL)
    else $error("idle entered without offset calibration");
  a_halt_in_wait: assert property ($past(power_mode) == ST_INSERT_WAIT &&
    power_mode == ST_INSERT_WAIT |-> cpu_halted)
    else $error("processor running in insertion wait");
  a_fast_keeps_hf: assert property ($past(power_mode) == ST_FAST_IDLE &&
    power_mode == ST_FAST_IDLE |-> hf_osc_enable)
    else $error("fast idle stopped the fast oscillator");
  a_hib_needs_ocv: assert property (power_mode == ST_HIBERNATE &&
    $past(power_mode) != ST_HIBERNATE |-> $past(ocv_valid))
    else $error("hibernate entered without a valid voltage reading");
  a_wake_in_low: assert property (wake_irq && !$past(wake_irq) |->
    $past(power_mode) inside {ST_IDLE, ST_FAST_IDLE, ST_HIBERNATE})
    else $error("wake trip outside the low-power modes");
  // ****
  // flags, counters and flash
  // ****
  a_flash_gate: assert property ($past(flash_write_req) |->
    flash_grant == ($past(voltage) >= $past(flash_ok_voltage)) && flash_refused == !flash_grant)
    else $error("flash grant does not follow the voltage check");
  a_hot_disabled: assert property (charge_hot_time == 0 && $past(charge_hot_time) == 0 |->
    !charge_hot_flag)
    else $error("charge hot flag set with zero hot time");
  a_term_clears: assert property (charge_term |-> ##[0:1] !charging_flag)
    else $error("charging flag still set after termination");
  a_reset_step: assert property (reset_count != $past(reset_count) |->
    reset_count == $past(reset_count) + 1'b1)
    else $error("reset counter moved by other than one");
endmodule : gauge_supervisor_checker
bind gauge_power_mode_supervisor gauge_supervisor_checker #(.RC_W(RC_W))
  i_gauge_supervisor_checker (.clk, .rst_b, .power_mode, .ocv_start, .profile_start,
  .cpu_halted, .hf_osc_enable, .ocv_valid, .flash_write_req, .voltage, .flash_ok_voltage,
  .flash_grant, .flash_refused, .charge_hot_time, .charge_hot_flag, .charge_term,
  .charging_flag, .reset_count, .wake_irq);

/* File: sim/host_link_model.sv */
// host side of the link: framed commands on a link clock of its own
// assumes the supervisor samples link inputs on rising link_clk edges
`timescale 1ns/1ps
module host_link_model (
  output logic link_clk,
  output logic link_frame_done,
  output logic link_addr_match,
  output logic link_cmd_reset,
  output logic link_cmd_hibernate,
  output logic link_cmd_temp_query
);
  initial begin
    link_clk = 1'b0;
    link_frame_done = 1'b0;
    {link_addr_match, link_cmd_temp_query, link_cmd_hibernate, link_cmd_reset} = 4'h5;
  end
  // the link clock only runs inside frames and for two cycles at reset, and stands low between them
  task automatic tick(input int n);
    repeat (n) begin
      #15 link_clk = 1'b1;
      #15 link_clk = 1'b0;
    end
  endtask : tick
  // kind bits are {temp query, hibernate, reset}; no kind is plain addressed traffic
  task automatic send_frame(input logic addr, input logic [2:0] kind);
    tick(2);
    link_frame_done = 1'b1;
    link_addr_match = addr;
    {link_cmd_temp_query, link_cmd_hibernate, link_cmd_reset} = kind;
    tick(1);
    link_frame_done = 1'b0;
    // released qualifiers flip so a stale value is never read as fresh
    {link_addr_match, link_cmd_temp_query, link_cmd_hibernate, link_cmd_reset} =
      ~{link_addr_match, link_cmd_temp_query, link_cmd_hibernate, link_cmd_reset};
    tick(2);
  endtask : send_frame
endmodule : host_link_model

/* File: sim/test_gauge_power_mode_supervisor.sv */
// self-checking bench for the gauge power-mode supervisor
// assumes the host link model and the bound checker are compiled alongside
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] %s expected %0h seen %0h", nm, (exp), (got)); \
    end \
  end
module test_gauge_power_mode_supervisor import gauge_pkg::*;;
  logic clk, rst_b, link_clk, link_frame_done, link_addr_match, link_cmd_reset;
  logic link_cmd_hibernate, link_cmd_temp_query, battery_present_pin, measure_tick;
  logic temp_source_select, taper_window_end, remaining_equals_full_on_term, capacity_update;
  logic good_polarity_select, idle_enable, fast_idle_enable, ocv_valid, ocv_done, profile_done;
  logic cal_done, cmd_done, sense_range_hi, sense_range_lo, wake_threshold_range, flash_write_req;
  logic battery_good_out, charge_hot_flag, discharge_hot_flag, charging_flag, charge_term;
  logic cpu_halted, hf_osc_enable, ocv_start, profile_start, cal_start, wake_irq;
  logic flash_grant, flash_refused;
  logic [1:0] power_feed_config;
  logic signed [DW-1:0] thermistor_input, internal_temp, avg_current, sense_uv, charge_hot_limit;
  logic signed [DW-1:0] charge_recovery, charge_current_threshold, discharge_hot_limit, thr;
  logic signed [DW-1:0] discharge_recovery, discharge_current_threshold, taper_current;
  logic signed [DW-1:0] inhibit_temp_low, inhibit_temp_high, temp_hys, idle_current, temperature;
  logic [DW-1:0] voltage, charge_hot_time, discharge_hot_time, window_gain_uah, charging_voltage;
  logic [DW-1:0] taper_voltage, full_charge_capacity, remaining_in, hibernate_current;
  logic [DW-1:0] hibernate_voltage, flash_ok_voltage, remaining_capacity;
  logic [7:0] reset_count;
  power_mode_t power_mode;
  int mismatches, n_compared, i;

  gauge_power_mode_supervisor i_gauge_power_mode_supervisor (.*);
  host_link_model i_host_link_model (.*);

  always #5 clk = ~clk;

  // ****
  // access tasks
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(2);
  endtask : pulse
  task automatic wait_mode(input power_mode_t m);
    for (int k = 0; k < 40 && power_mode !== m; k++) step(1);
    `CHK("power_mode", power_mode, m);
  endtask : wait_mode
  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, mismatches);
  endtask : done
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  // ****
  // tests
  // ****
  initial begin
    {clk, rst_b, battery_present_pin, measure_tick, taper_window_end, capacity_update} = '0;
    {remaining_equals_full_on_term, good_polarity_select, idle_enable, fast_idle_enable} = '0;
    {ocv_valid, ocv_done, profile_done, cal_done, cmd_done, flash_write_req} = '0;
    {sense_range_hi, sense_range_lo, wake_threshold_range, temp_source_select} = '0;
    {power_feed_config, avg_current, sense_uv, charge_hot_time, discharge_hot_time} = '0;
    {window_gain_uah, remaining_in, inhibit_temp_low} = '0;
    {thermistor_input, internal_temp, voltage} = {16'h0019, 16'h0014, 16'h0FA0};
    {charge_hot_limit, charge_recovery, charge_current_threshold} = {16'h002D, 16'h0028, 16'h000A};
    {discharge_hot_limit, discharge_recovery} = {16'h003C, 16'h0037};
    {discharge_current_threshold, taper_current} = {16'h000A, 16'h0032};
    {charging_voltage, taper_voltage, full_charge_capacity} = {16'h1068, 16'h0064, 16'h0BB8};
    {inhibit_temp_high, temp_hys, idle_current} = {16'h002D, 16'h0005, 16'h000A};
    {hibernate_current, hibernate_voltage, flash_ok_voltage} = {16'h0005, 16'h0BB8, 16'h0E10};
    fork
      step(6);
      i_host_link_model.tick(2);
    join
    rst_b = 1'b1;
    step(3);
    wait_mode(ST_INSERT_WAIT);
    i_host_link_model.send_frame(1'b1, 3'h0);
    wait_mode(ST_INSERT_SERVE);
    cmd_done = 1'b1;
    wait_mode(ST_INSERT_WAIT);
    cmd_done = 1'b0;
    battery_present_pin = 1'b1;
    wait_mode(ST_INIT_OCV);
    `CHK("battery_good_out", battery_good_out, 1'b1);
    ocv_valid = 1'b1;
    pulse(ocv_done);
    wait_mode(ST_INIT_PROFILE);
    `CHK("battery_good_out", battery_good_out, 1'b0);
    pulse(profile_done);
    wait_mode(ST_NORMAL);
    done("insertion");
    for (i = 0; i < 3; i++) i_host_link_model.send_frame(1'b1, 3'h1);
    i_host_link_model.send_frame(1'b0, 3'h1);
    step(6);
    `CHK("reset_count", reset_count, 8'h03);
    i_host_link_model.send_frame(1'b1, 3'h4);
    step(6);
    `CHK("temperature", temperature, 16'h0014);
    temp_source_select = 1'b1;
    thermistor_input = 16'h001E;
    pulse(measure_tick);
    `CHK("temperature", temperature, 16'h0014);
    i_host_link_model.send_frame(1'b1, 3'h4);
    step(6);
    `CHK("temperature", temperature, 16'h001E);
    done("counter and temperature");
    flash_write_req = 1'b1;
    for (i = -1; i < 2; i++) begin
      voltage = flash_ok_voltage + 16'(i);
      step(2);
      `CHK("flash_grant", flash_grant, i >= 0);
      `CHK("flash_refused", flash_refused, i < 0);
    end
    flash_write_req = 1'b0;
    power_feed_config = 2'h1;
    for (i = 0; i < 3; i++) begin
      // above the window, inside but within hysteresis, then inside the narrowed window
      thermistor_input = (i == 0) ? 16'h002E : (i == 1) ? 16'h002A : 16'h0028;
      pulse(measure_tick);
      pulse(measure_tick);
      `CHK("battery_good_out", battery_good_out, i < 2);
    end
    done("flash and inhibit");
    thermistor_input = 16'h002D;
    pulse(measure_tick);
    {avg_current, charge_hot_time} = {16'h0064, 16'h0003};
    step(1);
    pulse(measure_tick);
    pulse(measure_tick);
    `CHK("charge_hot_flag", charge_hot_flag, 1'b0);
    pulse(measure_tick);
    `CHK("charge_hot_flag", charge_hot_flag, 1'b1);
    thermistor_input = 16'h0028;
    pulse(measure_tick);
    pulse(measure_tick);
    `CHK("charge_hot_flag", charge_hot_flag, 1'b0);
    charge_hot_time = '0;
    {avg_current, window_gain_uah, voltage} = {16'h0014, 16'h00FB, 16'h1005};
    remaining_equals_full_on_term = 1'b1;
    pulse(taper_window_end);
    `CHK("charging_flag", charging_flag, 1'b1);
    pulse(taper_window_end);
    `CHK("charging_flag", charging_flag, 1'b0);
    `CHK("remaining_capacity", remaining_capacity, full_charge_capacity);
    {thermistor_input, avg_current, discharge_hot_time} = {16'h003C, 16'hFFEC, 16'h0001};
    repeat (2) pulse(measure_tick);
    `CHK("discharge_hot_flag", discharge_hot_flag, 1'b1);
    thermistor_input = 16'h0037;
    pulse(measure_tick);
    `CHK("discharge_hot_flag", discharge_hot_flag, 1'b0);
    {avg_current, voltage} = {16'h0000, 16'h0FA0};
    done("temperature flag and termination");
    idle_enable = 1'b1;
    wait_mode(ST_IDLE_CAL);
    cal_done = 1'b1;
    for (i = 0; i < 8; i++) begin
      {sense_range_hi, sense_range_lo, wake_threshold_range} = 3'(i);
      thr = 16'h04E2 << (i / 2 - 1 + i % 2);
      sense_uv = '0;
      wait_mode(ST_IDLE);
      sense_uv = (i < 2) ? 16'sh7FFF : (i % 2) ? -thr : thr;
      step(4);
      `CHK("power_mode", power_mode, ST_IDLE);
      if (i >= 2) begin
        sense_uv = (i % 2) ? -thr - 16'sh0001 : thr + 16'sh0001;
        wait_mode(ST_NORMAL);
      end
    end
    sense_uv = '0;
    wait_mode(ST_IDLE);
    avg_current = 16'h0014;
    wait_mode(ST_NORMAL);
    avg_current = '0;
    fast_idle_enable = 1'b1;
    wait_mode(ST_FAST_IDLE);
    `CHK("hf_osc_enable", hf_osc_enable, 1'b1);
    avg_current = 16'h0014;
    wait_mode(ST_NORMAL);
    {avg_current, idle_enable, ocv_valid} = '0;
    wait_mode(ST_FAST_IDLE);
    fast_idle_enable = 1'b0;
    i_host_link_model.send_frame(1'b1, 3'h0);
    `CHK("power_mode", power_mode, ST_NORMAL);
    done("idle modes");
    i_host_link_model.send_frame(1'b1, 3'h2);
    step(6);
    `CHK("power_mode", power_mode, ST_NORMAL);
    ocv_valid = 1'b1;
    avg_current = '0;
    wait_mode(ST_HIBERNATE);
    i_host_link_model.send_frame(1'b0, 3'h0);
    step(6);
    `CHK("power_mode", power_mode, ST_HIBERNATE);
    i_host_link_model.send_frame(1'b1, 3'h0);
    wait_mode(ST_INIT_OCV);
    done("hibernate");
    wrap_up();
  end
endmodule : test_gauge_power_mode_supervisor
